// File: inc/bsu_pkg.sv
// Shared constants, enumerations and carrier structs of the bit scan unit.
`default_nettype none
package bsu_pkg;
	localparam logic [7:0]  OPC_SCAN_LOW    = 8'hBC;
	localparam logic [7:0]  OPC_SCAN_HIGH   = 8'hBD;
	localparam int          OPER_W          = 32;
	localparam int          IDX_W           = 5;
	localparam int          FCODE_W         = 16;
	localparam logic [3:0]  OFS_CTRL        = 4'h0;
	localparam logic [3:0]  OFS_STATUS      = 4'h4;
	localparam logic [3:0]  OFS_RETIRE_CNT  = 4'h8;
	localparam logic [3:0]  OFS_FAULT_CNT   = 4'hC;
	localparam int          CTRL_PROT_BIT   = 0;
	localparam int          CTRL_ALIGN_BIT  = 1;
	localparam int          CTRL_CPL_LSB    = 2;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam int          STAT_IDX_LSB    = 0;
	localparam int          STAT_ZF_BIT     = 8;
	localparam int          STAT_KIND_LSB   = 12;
	localparam logic [1:0]  CPL_USER        = 2'h3;
	localparam logic [32:0] SPAN_WORD       = 33'h000000001;
	localparam logic [32:0] SPAN_DWORD      = 33'h000000003;

	typedef enum logic [2:0] {
		SEG_CODE   = 3'h0,
		SEG_STACK  = 3'h1,
		SEG_DATA   = 3'h2,
		SEG_EXTRA  = 3'h3,
		SEG_FOURTH = 3'h4,
		SEG_FIFTH  = 3'h5
	} bsu_seg_t;

	typedef enum logic [2:0] {
		FLT_NONE  = 3'h0,
		FLT_GP    = 3'h1,
		FLT_SS    = 3'h2,
		FLT_PF    = 3'h3,
		FLT_AC    = 3'h4
	} bsu_fault_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bsu_bus_state_t;

	typedef struct packed {
		logic                valid;
		logic [7:0]          opcode;
		logic                size32;
		logic                src_mem;
		bsu_seg_t            seg;
		logic [2:0]          dst;
		logic [OPER_W-1:0]   src_reg;
		logic [OPER_W-1:0]   mem_data;
		logic [31:0]         ea;
		logic [31:0]         seg_limit;
		logic                sel_null;
		logic                page_miss;
		logic [FCODE_W-1:0]  pf_code;
	} bsu_op_t;

	typedef struct packed {
		logic                retire;
		logic                dst_we;
		logic                size32;
		logic [2:0]          dst;
		logic [OPER_W-1:0]   value;
		logic                flags_we;
		logic                zero_result_flag;
	} bsu_res_t;

	typedef struct packed {
		logic                valid;
		bsu_fault_t          kind;
		logic                code_valid;
		logic [FCODE_W-1:0]  code;
	} bsu_flt_t;
endpackage
`default_nettype wire

// File: src/bsu_scan.sv
// Priority encoder that finds the lowest and the highest set bit of an operand.
`timescale 1ns/10ps
`default_nettype none
module bsu_scan #(
	parameter int WIDTH = 32,
	parameter int IW    = 5
) (
	input  wire logic [WIDTH-1:0] operand,
	output logic      [IW-1:0]    low_index,
	output logic      [IW-1:0]    high_index,
	output logic                  all_zero
);
	generate
		if (WIDTH < 2 || (WIDTH & (WIDTH - 1)) != 0 || (1 << IW) != WIDTH) begin : g_bad
			$error("bsu_scan needs a power of two width matching its index width.");
		end
	endgenerate

	always_comb begin
		low_index  = '0;
		high_index = '0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (operand[i]) begin
				low_index = IW'(i);
			end
		end
		for (int i = 0; i < WIDTH; i++) begin
			if (operand[i]) begin
				high_index = IW'(i);
			end
		end
		all_zero = ~|operand;
	end
endmodule // bsu_scan
`default_nettype wire

// File: src/bsu_fault_check.sv
// Fault screening of the memory source operand, in a fixed priority order.
`timescale 1ns/10ps
`default_nettype none
module bsu_fault_check (
	input  wire logic                         src_mem,
	input  wire logic                         size32,
	input  wire bsu_pkg::bsu_seg_t            seg,
	input  wire logic [31:0]                  ea,
	input  wire logic [31:0]                  seg_limit,
	input  wire logic                         sel_null,
	input  wire logic                         page_miss,
	input  wire logic [bsu_pkg::FCODE_W-1:0]  pf_code,
	input  wire logic                         prot,
	input  wire logic                         align_en,
	input  wire logic [1:0]                   cpl,
	output bsu_pkg::bsu_fault_t               kind,
	output logic                              code_valid,
	output logic [bsu_pkg::FCODE_W-1:0]       code
);
	logic [32:0] last_byte;
	logic        over;
	logic        misalign;
	logic        data_like;

	always_comb begin
		last_byte = {1'b0, ea} + (size32 ? bsu_pkg::SPAN_DWORD : bsu_pkg::SPAN_WORD);
		over      = last_byte > {1'b0, seg_limit};
		misalign  = size32 ? (|ea[1:0]) : ea[0];
		data_like = seg != bsu_pkg::SEG_CODE && seg != bsu_pkg::SEG_STACK;
		kind       = bsu_pkg::FLT_NONE;
		code_valid = 1'b0;
		code       = '0;
		// Real address mode pushes no error code, so code_valid follows the mode.
		if (!src_mem) begin
			kind = bsu_pkg::FLT_NONE;
		end else if (prot && data_like && sel_null) begin
			kind       = bsu_pkg::FLT_GP;
			code_valid = 1'b1;
		end else if (over && seg == bsu_pkg::SEG_STACK) begin
			kind       = bsu_pkg::FLT_SS;
			code_valid = prot;
		end else if (over) begin
			kind       = bsu_pkg::FLT_GP;
			code_valid = prot;
		end else if (prot && page_miss) begin
			kind       = bsu_pkg::FLT_PF;
			code_valid = 1'b1;
			code       = pf_code;
		end else if (prot && align_en && cpl == bsu_pkg::CPL_USER && misalign) begin
			kind       = bsu_pkg::FLT_AC;
			code_valid = 1'b1;
		end
	end
endmodule // bsu_fault_check
`default_nettype wire

// File: src/bsu_top.sv
// Bit scan execution unit with fault screening and an Avalon-MM control slave.
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Forward scan writes lowest set bit index.
// - Reverse scan writes highest set bit index.
// - Index counts upward from bit zero.
// - Zero source sets zero flag, else clears.
// - Other status flags are left undefined.
// - Sixteen and 32-bit, register or memory source.
// - Segment limit overrun gives protection fault.
// - Null data selector gives protection fault.
// - Stack limit overrun gives stack fault.
// - Paging miss gives page fault with code.
// - Misaligned user access gives alignment fault.
module bsu_top (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire bsu_pkg::bsu_op_t  op_in,
	output bsu_pkg::bsu_res_t      res_out,
	output bsu_pkg::bsu_flt_t      flt_out,
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest
);
	localparam int W  = bsu_pkg::OPER_W;
	localparam int IW = bsu_pkg::IDX_W;

	bsu_pkg::bsu_res_t        res_reg;
	bsu_pkg::bsu_res_t        res_next;
	bsu_pkg::bsu_flt_t        flt_reg;
	bsu_pkg::bsu_flt_t        flt_next;
	logic [7:0]               ctrl_reg;
	logic [7:0]               ctrl_next;
	logic [IW-1:0]            last_idx_reg;
	logic [IW-1:0]            last_idx_next;
	logic                     last_zf_reg;
	logic                     last_zf_next;
	bsu_pkg::bsu_fault_t      last_kind_reg;
	bsu_pkg::bsu_fault_t      last_kind_next;
	logic [31:0]              retire_cnt_reg;
	logic [31:0]              retire_cnt_next;
	logic [31:0]              fault_cnt_reg;
	logic [31:0]              fault_cnt_next;
	bsu_pkg::bsu_bus_state_t  bus_state_reg;
	bsu_pkg::bsu_bus_state_t  bus_state_next;
	logic                     wait_reg;
	logic                     wait_next;
	logic [31:0]              rdata_reg;
	logic [31:0]              rdata_next;
	logic [W-1:0]             src_hold_reg;
	logic [W-1:0]             src_hold_next;
	logic                     low_hold_reg;
	logic                     low_hold_next;

	logic [W-1:0]             src_raw;
	logic [W-1:0]             src_val;
	logic [IW-1:0]            low_index;
	logic [IW-1:0]            high_index;
	logic                     src_zero;
	bsu_pkg::bsu_fault_t      fkind;
	logic                     fcode_valid;
	logic [bsu_pkg::FCODE_W-1:0] fcode;
	logic                     prot;
	logic                     align_en;
	logic [1:0]               cpl;
	logic                     known_op;
	logic                     is_low;
	logic                     retire_ev;
	logic                     fault_ev;
	logic                     bus_access;

	assign prot     = ctrl_reg[bsu_pkg::CTRL_PROT_BIT];
	assign align_en = ctrl_reg[bsu_pkg::CTRL_ALIGN_BIT];
	assign cpl      = ctrl_reg[bsu_pkg::CTRL_CPL_LSB +: 2];
	assign is_low   = op_in.opcode == bsu_pkg::OPC_SCAN_LOW;
	assign known_op = is_low || op_in.opcode == bsu_pkg::OPC_SCAN_HIGH;

	// A 16-bit scan masks the upper half, so both indexes stay below sixteen.
	assign src_raw = op_in.src_mem ? op_in.mem_data : op_in.src_reg;
	assign src_val = op_in.size32 ? src_raw : {16'h0000, src_raw[15:0]};

	bsu_scan #(
		.WIDTH (W),
		.IW    (IW)
	) u_scan (
		.operand    (src_val),
		.low_index  (low_index),
		.high_index (high_index),
		.all_zero   (src_zero)
	);

	bsu_fault_check u_fault (
		.src_mem    (op_in.src_mem),
		.size32     (op_in.size32),
		.seg        (op_in.seg),
		.ea         (op_in.ea),
		.seg_limit  (op_in.seg_limit),
		.sel_null   (op_in.sel_null),
		.page_miss  (op_in.page_miss),
		.pf_code    (op_in.pf_code),
		.prot       (prot),
		.align_en   (align_en),
		.cpl        (cpl),
		.kind       (fkind),
		.code_valid (fcode_valid),
		.code       (fcode)
	);

	assign fault_ev  = op_in.valid && known_op && fkind != bsu_pkg::FLT_NONE;
	assign retire_ev = op_in.valid && known_op && fkind == bsu_pkg::FLT_NONE;

	always_comb begin
		res_next       = '0;
		flt_next       = '0;
		last_idx_next  = last_idx_reg;
		last_zf_next   = last_zf_reg;
		last_kind_next = last_kind_reg;
		src_hold_next  = src_hold_reg;
		low_hold_next  = low_hold_reg;
		if (retire_ev) begin
			res_next.retire           = 1'b1;
			res_next.size32           = op_in.size32;
			res_next.dst              = op_in.dst;
			res_next.value            = {27'h0000000, is_low ? low_index : high_index};
			// A zero source leaves the destination as it was, one legal undefined value.
			res_next.dst_we           = !src_zero;
			res_next.flags_we         = 1'b1;
			// Only the zero flag is produced; the other flags keep their old contents.
			res_next.zero_result_flag = src_zero;
			last_idx_next             = is_low ? low_index : high_index;
			last_zf_next              = src_zero;
			last_kind_next            = bsu_pkg::FLT_NONE;
			src_hold_next             = src_val;
			low_hold_next             = is_low;
		end else if (fault_ev) begin
			// Faults write nothing back and do not retire the instruction.
			flt_next.valid      = 1'b1;
			flt_next.kind       = fkind;
			flt_next.code_valid = fcode_valid;
			flt_next.code       = fcode;
			last_kind_next      = fkind;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			res_reg       <= '0;
			flt_reg       <= '0;
			last_idx_reg  <= '0;
			last_zf_reg   <= 1'b0;
			last_kind_reg <= bsu_pkg::FLT_NONE;
			src_hold_reg  <= '0;
			low_hold_reg  <= 1'b0;
		end else begin
			res_reg       <= res_next;
			flt_reg       <= flt_next;
			last_idx_reg  <= last_idx_next;
			last_zf_reg   <= last_zf_next;
			last_kind_reg <= last_kind_next;
			src_hold_reg  <= src_hold_next;
			low_hold_reg  <= low_hold_next;
		end
	end

	assign res_out = res_reg;
	assign flt_out = flt_reg;

	// One wait state per access keeps the read mux off the bus path.
	assign bus_access = bus_state_reg == bsu_pkg::BUS_ACK;

	always_comb begin
		bus_state_next  = bus_state_reg;
		ctrl_next       = ctrl_reg;
		retire_cnt_next = retire_cnt_reg;
		fault_cnt_next  = fault_cnt_reg;
		rdata_next      = rdata_reg;
		case (bus_state_reg)
			bsu_pkg::BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_state_next = bsu_pkg::BUS_ACK;
				end
			end
			bsu_pkg::BUS_ACK: begin
				bus_state_next = bsu_pkg::BUS_IDLE;
			end
			default: begin
				bus_state_next = bsu_pkg::BUS_IDLE;
			end
		endcase
		wait_next = bus_state_next != bsu_pkg::BUS_ACK;
		if (bus_state_next == bsu_pkg::BUS_ACK) begin
			case (avs_address)
				bsu_pkg::OFS_CTRL:       rdata_next = {24'h000000, ctrl_reg};
				bsu_pkg::OFS_STATUS:     rdata_next = {17'h00000, last_kind_reg, 3'h0,
					last_zf_reg, 3'h0, last_idx_reg};
				bsu_pkg::OFS_RETIRE_CNT: rdata_next = retire_cnt_reg;
				bsu_pkg::OFS_FAULT_CNT:  rdata_next = fault_cnt_reg;
				default:                 rdata_next = 32'h00000000;
			endcase
		end
		if (bus_access && avs_write && avs_address == bsu_pkg::OFS_CTRL && avs_byteenable[0]) begin
			ctrl_next = avs_writedata[7:0];
		end
		// A write clears a counter, but an event in the same cycle still counts.
		if (bus_access && avs_write && avs_address == bsu_pkg::OFS_RETIRE_CNT) begin
			retire_cnt_next = 32'h00000000;
		end
		if (bus_access && avs_write && avs_address == bsu_pkg::OFS_FAULT_CNT) begin
			fault_cnt_next = 32'h00000000;
		end
		if (retire_ev) begin
			retire_cnt_next = retire_cnt_next + 32'h00000001;
		end
		if (fault_ev) begin
			fault_cnt_next = fault_cnt_next + 32'h00000001;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bus_state_reg  <= bsu_pkg::BUS_IDLE;
			wait_reg       <= 1'b1;
			rdata_reg      <= 32'h00000000;
			ctrl_reg       <= bsu_pkg::CTRL_RESET;
			retire_cnt_reg <= 32'h00000000;
			fault_cnt_reg  <= 32'h00000000;
		end else begin
			bus_state_reg  <= bus_state_next;
			wait_reg       <= wait_next;
			rdata_reg      <= rdata_next;
			ctrl_reg       <= ctrl_next;
			retire_cnt_reg <= retire_cnt_next;
			fault_cnt_reg  <= fault_cnt_next;
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;

	logic [32:0] chk_last;
	logic        chk_over;
	logic        chk_data_like;
	assign chk_last      = {1'b0, op_in.ea} + (op_in.size32 ? bsu_pkg::SPAN_DWORD
		: bsu_pkg::SPAN_WORD);
	assign chk_over      = chk_last > {1'b0, op_in.seg_limit};
	assign chk_data_like = op_in.seg != bsu_pkg::SEG_CODE && op_in.seg != bsu_pkg::SEG_STACK;

	property p_low_index;
		@(posedge sys_clk) disable iff (!rstn)
		res_reg.retire && low_hold_reg && !res_reg.zero_result_flag |->
			src_hold_reg[res_reg.value[IW-1:0]] &&
			((src_hold_reg & ((32'h00000001 << res_reg.value[IW-1:0]) - 32'h00000001)) == '0);
	endproperty
	a_low_index: assert property (p_low_index) else $error("Forward scan index wrong.");

	property p_high_index;
		@(posedge sys_clk) disable iff (!rstn)
		res_reg.retire && !low_hold_reg && !res_reg.zero_result_flag |->
			(src_hold_reg >> res_reg.value[IW-1:0]) == 32'h00000001;
	endproperty
	a_high_index: assert property (p_high_index) else $error("Reverse scan index wrong.");

	property p_bit_zero;
		@(posedge sys_clk) disable iff (!rstn)
		retire_ev && is_low && src_val[0] |=> res_reg.value == 32'h00000000 && res_reg.dst_we;
	endproperty
	a_bit_zero: assert property (p_bit_zero) else $error("Bit zero not reported as zero.");

	property p_zero_flag;
		@(posedge sys_clk) disable iff (!rstn)
		retire_ev |=> res_reg.retire && res_reg.zero_result_flag == (src_hold_reg == '0)
			&& res_reg.dst_we == (src_hold_reg != '0);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("Zero flag mismatch.");

	property p_half_width;
		@(posedge sys_clk) disable iff (!rstn)
		retire_ev && !op_in.size32 |=> !res_reg.size32 && res_reg.value < 32'h00000010;
	endproperty
	a_half_width: assert property (p_half_width) else $error("16-bit scan out of range.");

	property p_gp_limit;
		@(posedge sys_clk) disable iff (!rstn)
		op_in.valid && known_op && op_in.src_mem && chk_over && op_in.seg != bsu_pkg::SEG_STACK
			&& !(prot && chk_data_like && op_in.sel_null) |=>
			flt_reg.valid && flt_reg.kind == bsu_pkg::FLT_GP && flt_reg.code == '0;
	endproperty
	a_gp_limit: assert property (p_gp_limit) else $error("Limit overrun not faulted.");

	property p_null_sel;
		@(posedge sys_clk) disable iff (!rstn)
		op_in.valid && known_op && op_in.src_mem && prot && chk_data_like && op_in.sel_null |=>
			flt_reg.kind == bsu_pkg::FLT_GP && flt_reg.code_valid && flt_reg.code == '0;
	endproperty
	a_null_sel: assert property (p_null_sel) else $error("Null selector not faulted.");

	property p_stack;
		@(posedge sys_clk) disable iff (!rstn)
		op_in.valid && known_op && op_in.src_mem && chk_over && op_in.seg == bsu_pkg::SEG_STACK |=>
			flt_reg.kind == bsu_pkg::FLT_SS && flt_reg.code_valid == $past(prot);
	endproperty
	a_stack: assert property (p_stack) else $error("Stack overrun not faulted.");

	property p_page;
		@(posedge sys_clk) disable iff (!rstn)
		op_in.valid && known_op && op_in.src_mem && prot && op_in.page_miss && !chk_over
			&& !(chk_data_like && op_in.sel_null) |=>
			flt_reg.kind == bsu_pkg::FLT_PF && flt_reg.code == $past(op_in.pf_code);
	endproperty
	a_page: assert property (p_page) else $error("Page fault code lost.");

	property p_align;
		@(posedge sys_clk) disable iff (!rstn)
		fault_ev && fkind == bsu_pkg::FLT_AC |->
			prot && align_en && cpl == bsu_pkg::CPL_USER ##1 flt_reg.kind == bsu_pkg::FLT_AC;
	endproperty
	a_align: assert property (p_align) else $error("Alignment fault without cause.");

	property p_fault_blocks;
		@(posedge sys_clk) disable iff (!rstn)
		fault_ev |=> flt_reg.valid && !res_reg.retire && !res_reg.dst_we && !res_reg.flags_we
			&& last_idx_reg == $past(last_idx_reg) && last_zf_reg == $past(last_zf_reg);
	endproperty
	a_fault_blocks: assert property (p_fault_blocks) else $error("Faulted scan retired.");
endmodule // bsu_top
`default_nettype wire

// File: sim/bsu_dec_model.sv
// Issue model of the decoder and memory pipeline that feed scan operations to the unit.
`timescale 1ns/10ps
`default_nettype none
module bsu_dec_model (
	input  wire logic            sys_clk,
	input  wire logic            rstn,
	output var bsu_pkg::bsu_op_t op_out
);
	bsu_pkg::bsu_op_t q[$];
	bsu_pkg::bsu_op_t idle;
	// Between issues every field but valid flips each cycle, so a stale operand never looks live.
	always_comb begin
		idle       = ~op_out;
		idle.valid = 1'b0;
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			op_out <= '0;
		end else if (q.size() > 0) begin
			op_out <= q.pop_front();
		end else begin
			op_out <= idle;
		end
	end
endmodule // bsu_dec_model
`default_nettype wire

// File: sim/bsu_tb.sv
// Self-checking testbench of the bit scan unit with a reference model and bus tasks.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic              sys_clk;
	logic              rstn;
	bsu_pkg::bsu_op_t  op;
	bsu_pkg::bsu_res_t res_out;
	bsu_pkg::bsu_flt_t flt_out;
	logic [3:0]        avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	bsu_pkg::bsu_res_t exp_r;
	bsu_pkg::bsu_flt_t exp_f;
	logic [3:0]        ctrl_m;
	logic [31:0]       rnd;
	logic [31:0]       rd;
	int                bad_count;
	int                checks;
	int                cyc;
	int                ret_m;
	int                flt_m;
	logic [31:0]       vals[6] = '{32'h0, 32'h1, 32'h80000000, 32'h00018000, 32'hFFFF0000, 32'h100};
	logic [3:0]        modes[6] = '{4'h0, 4'h1, 4'h3, 4'hF, 4'hB, 4'hD};

	bsu_dec_model u_dec (.sys_clk(sys_clk), .rstn(rstn), .op_out(op));
	bsu_top u_bsu_top (.sys_clk(sys_clk), .rstn(rstn), .op_in(op), .res_out(res_out),
		.flt_out(flt_out), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic report_and_stop();
		if (bad_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// Reference result of one issued operation under the given control settings.
	function automatic void model(input bsu_pkg::bsu_op_t o, input logic [3:0] c,
		output bsu_pkg::bsu_res_t r, output bsu_pkg::bsu_flt_t f);
		logic [31:0] v;
		logic [32:0] top;
		logic        mis;
		int          idx;
		r = '0;
		f = '0;
		if (!(o.valid && (o.opcode == bsu_pkg::OPC_SCAN_LOW || o.opcode == bsu_pkg::OPC_SCAN_HIGH)))
			return;
		v = o.src_mem ? o.mem_data : o.src_reg;
		if (!o.size32) v[31:16] = 16'h0000;
		top = {1'b0, o.ea} + (o.size32 ? bsu_pkg::SPAN_DWORD : bsu_pkg::SPAN_WORD);
		mis = o.size32 ? (o.ea[1:0] != 2'h0) : o.ea[0];
		if (o.src_mem) begin
			if (c[0] && o.sel_null && o.seg inside {bsu_pkg::SEG_DATA, bsu_pkg::SEG_EXTRA,
				bsu_pkg::SEG_FOURTH, bsu_pkg::SEG_FIFTH}) f.kind = bsu_pkg::FLT_GP;
			else if (top > {1'b0, o.seg_limit})
				f.kind = (o.seg == bsu_pkg::SEG_STACK) ? bsu_pkg::FLT_SS : bsu_pkg::FLT_GP;
			else if (c[0] && o.page_miss) begin
				f.kind = bsu_pkg::FLT_PF;
				f.code = o.pf_code;
			end else if (c[0] && c[1] && c[3:2] == bsu_pkg::CPL_USER && mis)
				f.kind = bsu_pkg::FLT_AC;
		end
		if (f.kind != bsu_pkg::FLT_NONE) begin
			f.valid = 1'b1;
			f.code_valid = c[0];
			return;
		end
		idx = 0;
		for (int i = 0; i < 32; i++) begin
			if (o.opcode == bsu_pkg::OPC_SCAN_HIGH && v[i]) idx = i;
			if (o.opcode == bsu_pkg::OPC_SCAN_LOW && v[31-i]) idx = 31 - i;
		end
		r.retire = 1'b1;
		r.flags_we = 1'b1;
		r.size32 = o.size32;
		r.dst = o.dst;
		r.zero_result_flag = (v == 32'h0);
		r.dst_we = (v != 32'h0);
		r.value = idx;
	endfunction

	// Results are due one edge after the operation; the value is free when the source is zero.
	always @(posedge sys_clk) begin
		if (rstn) begin
			if (exp_r.zero_result_flag) exp_r.value = res_out.value;
			chk(res_out, exp_r);
			chk(flt_out, exp_f);
			model(op, ctrl_m, exp_r, exp_f);
			ret_m += exp_r.retire;
			flt_m += exp_f.valid;
		end else begin
			exp_r = '0;
			exp_f = '0;
		end
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= 4'hF;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr_ctrl(input logic [31:0] d);
		av(1'b1, bsu_pkg::OFS_CTRL, d);
		ctrl_m = d[3:0];
	endtask

	task automatic drain();
		while (u_dec.q.size() > 0) @(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic send_reg(input logic [7:0] opc, input logic s32, input logic [31:0] v);
		bsu_pkg::bsu_op_t o;
		o = '0;
		o.valid = 1'b1;
		o.opcode = opc;
		o.size32 = s32;
		o.src_reg = v;
		o.dst = v[2:0];
		u_dec.q.push_back(o);
	endtask

	task automatic send_rand();
		bsu_pkg::bsu_op_t o;
		logic [31:0]      r;
		r = xs(rnd);
		rnd = xs(r);
		o.valid = 1'b1;
		o.opcode = (r[2:0] == 3'h0) ? 8'h00 : (r[3] ? bsu_pkg::OPC_SCAN_LOW : bsu_pkg::OPC_SCAN_HIGH);
		o.size32 = r[4];
		o.src_mem = r[5];
		o.seg = (r[10:8] > 3'h5) ? bsu_pkg::SEG_DATA : bsu_pkg::bsu_seg_t'(r[10:8]);
		o.dst = r[13:11];
		o.src_reg = (r[15:14] == 2'h0) ? 32'h0 : rnd >> r[20:16];
		rnd = xs(rnd);
		o.mem_data = (r[7:6] == 2'h0) ? 32'h0 : rnd >> r[25:21];
		rnd = xs(rnd);
		o.ea = rnd;
		o.seg_limit = rnd + {29'h0, r[28:26]} - 32'h2;
		o.sel_null = r[29] & r[30];
		o.page_miss = r[31] & r[1];
		o.pf_code = rnd[31:16];
		u_dec.q.push_back(o);
	endtask

	initial begin
		rstn = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		ctrl_m = 4'h0;
		rnd = 32'h031D9F08;
		bad_count = 0;
		checks = 0;
		cyc = 0;
		ret_m = 0;
		flt_m = 0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		av(1'b0, bsu_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		wr_ctrl(32'hFFFFFF0A);
		av(1'b0, bsu_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0000000A);
		av(1'b0, 4'h6, 32'h0);
		chk(rd, 32'h0);
		wr_ctrl(32'h0);
		// Back-to-back edge operands of both scans and both widths, register source.
		for (int k = 0; k < 24; k++) send_reg(k[0] ? bsu_pkg::OPC_SCAN_HIGH :
			bsu_pkg::OPC_SCAN_LOW, k[1], vals[k/4]);
		drain();
		foreach (modes[m]) begin
			wr_ctrl({28'h0, modes[m]});
			for (int k = 0; k < 80; k++) send_rand();
			drain();
		end
		av(1'b0, bsu_pkg::OFS_RETIRE_CNT, 32'h0);
		chk(rd, ret_m);
		av(1'b0, bsu_pkg::OFS_FAULT_CNT, 32'h0);
		chk(rd, flt_m);
		av(1'b1, bsu_pkg::OFS_RETIRE_CNT, 32'h0);
		av(1'b0, bsu_pkg::OFS_RETIRE_CNT, 32'h0);
		chk(rd, 32'h0);
		send_reg(bsu_pkg::OPC_SCAN_LOW, 1'b1, 32'hF000_0100);
		drain();
		av(1'b0, bsu_pkg::OFS_STATUS, 32'h0);
		chk(rd[8:0], 9'h008);
		// A second reset in mid-run must bring the control register back to zero.
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		ctrl_m = 4'h0;
		av(1'b0, bsu_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		send_reg(bsu_pkg::OPC_SCAN_HIGH, 1'b0, 32'h0000_4001);
		drain();
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
